// ---- rtl/ipsb_defines.vh ----
`ifndef IPSB_DEFINES_VH
`define IPSB_DEFINES_VH

`define IPSB_FLAG_MBOX 2'd0
`define IPSB_FLAG_TERM 2'd1
`define IPSB_FLAG_CONF 2'd2
`define IPSB_FLAG_CAL 2'd3
`define IPSB_CLK_MHZ 200
`define IPSB_WDOG_MS 1000
`define IPSB_WDOG_CYC (`IPSB_WDOG_MS * 1000 * `IPSB_CLK_MHZ)
`define IPSB_ZERO4 4'h0
`define IPSB_ONE16 16'h0001
`define IPSB_ONE32 32'h0000_0001
`define IPSB_ZERO32 32'h0000_0000

`endif

// ---- rtl/ipsb_fifo.v ----
`timescale 1ns/100ps
`default_nettype none
module ipsb_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH_LOG2 = 3
) (
	input wire clk_in,
	input wire rst_n_in,
	input wire push_in,
	input wire [WIDTH-1:0] push_data_in,
	input wire pop_in,
	output reg [WIDTH-1:0] pop_data_out,
	output reg pop_valid_out,
	output reg full_out,
	output reg empty_out
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
	reg [DEPTH_LOG2:0] wr_ff;
	reg [DEPTH_LOG2:0] rd_ff;
	wire do_push;
	wire do_pop;
	wire [DEPTH_LOG2:0] nxt_wr;
	wire [DEPTH_LOG2:0] nxt_rd;
	assign do_push = push_in && !full_out;
	assign do_pop = pop_in && !empty_out;
	assign nxt_wr = do_push ? wr_ff + 1'b1 : wr_ff;
	assign nxt_rd = do_pop ? rd_ff + 1'b1 : rd_ff;
	always @(posedge clk_in) begin
		if (do_push) begin
			mem_ff[wr_ff[DEPTH_LOG2-1:0]] <= push_data_in;
		end
	end
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ff <= {(DEPTH_LOG2+1){1'b0}};
			rd_ff <= {(DEPTH_LOG2+1){1'b0}};
			pop_data_out <= {WIDTH{1'b0}};
			pop_valid_out <= 1'b0;
			full_out <= 1'b0;
			empty_out <= 1'b1;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			pop_valid_out <= do_pop;
			if (do_pop) begin
				pop_data_out <= mem_ff[rd_ff[DEPTH_LOG2-1:0]];
			end
			full_out <= (nxt_wr[DEPTH_LOG2] != nxt_rd[DEPTH_LOG2]) &&
				(nxt_wr[DEPTH_LOG2-1:0] == nxt_rd[DEPTH_LOG2-1:0]);
			empty_out <= (nxt_wr == nxt_rd);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/ipsb_top.v ----
// Functional notes
// (RL1) Outbound mailbox addresses queued, peer pops until empty
// (RL2) Peer pushes inbound mailbox addresses into queue
// (RL3) Four causes per direction share one line
// (RL4) Four flags per direction, separate handlers
// (RL5) Attention and confirm flags, process index 0-3
// (RL6) Peer raises inbound mailbox, terminal, confirms
// (RL7) Inbound flag starts its matching local handler
// (RL8) Local side raises mailbox, terminal, calendar flags
// (RL9) Peer answers calendar command with confirm
// (RL10) Taken interrupt: disable source, then clear step
// (RL11) Clear step: clear one flag, dispatch handler
// (RL12) Set waits until flag clear, then line
// (RL13) Flag chosen by two-bit index 0-3
// (RL14) Operator comm console mode skips waiting
// (RL15) Pending check: loop back or re-enable line
// (RL16) Re-read after re-enable; reassert, restart
// (RL17) Nothing left: scratch bit enters periodic service
// (RL18) Watchdog after second request raises power fail
// (RL19) Unknown instruction number raises illegal trap
// (RL20) Peer interrupt takes address from inbound queue
// (RL21) Asynchronous mailbox starts coalescing timer instead
// (RL22) Timer zero or byte threshold triggers processing
// (RL23) Simultaneous set and clear: set wins
`timescale 1ns/100ps
`default_nettype none
`include "ipsb_defines.vh"
module ipsb_top #(
	parameter ADDR_W = 16,
	parameter FIFO_LOG2 = 3,
	parameter TIMER_W = 16,
	parameter WDOG_CYCLES = `IPSB_WDOG_CYC,
	parameter [127:0] IOX_VALID_MAP = {128{1'b1}},
	parameter [15:0] ASYNC_MAP = 16'h0000
) (
	input wire clk_in,
	input wire rst_n_in,
	// Outbound address queue, local pushes, peer pops
	input wire out_push_in,
	input wire [ADDR_W-1:0] out_push_addr_in,
	input wire out_pop_in,
	output reg [ADDR_W-1:0] out_pop_addr_out,
	output reg out_pop_valid_out,
	output reg out_empty_out,
	output reg out_full_out,
	// Inbound address queue, peer pushes
	input wire in_push_in,
	input wire [ADDR_W-1:0] in_push_addr_in,
	input wire in_full_ack_in,
	output reg in_full_out,
	// Local raise request
	input wire raise_peer_signal_in,
	input wire [1:0] raise_index_in,
	input wire operator_comm_active_in,
	input wire peer_is_console_in,
	output reg raise_busy_out,
	// Flags toward peer, peer clears
	input wire [3:0] peer_clear_in,
	output reg [3:0] out_flags_out,
	output reg peer_irq_out,
	// Flags from peer, peer sets
	input wire [3:0] peer_set_in,
	output reg [3:0] in_flags_out,
	// Local service: start handling when line up
	input wire handler_done_in,
	input wire periodic_call_request_in,
	output reg [3:0] dispatch_out,
	output reg periodic_service_entry_out,
	output reg local_irq_enable_out,
	// Instruction lookup
	input wire instr_valid_in,
	input wire [6:0] instr_num_in,
	output reg instruction_dispatch_out,
	output reg illegal_instr_out,
	// Coalescing timer
	input wire [3:0] mbox_slot_in,
	input wire [TIMER_W-1:0] timer_initial_value_in,
	input wire [TIMER_W-1:0] min_bytes_threshold_in,
	input wire [TIMER_W-1:0] byte_count_in,
	output reg [ADDR_W-1:0] level_queue_addr_out,
	output reg level_queue_valid_out,
	output reg coalesce_timer_entry_out,
	output reg power_fail_out
);
	localparam ST_IDLE = 6'b000001;
	localparam ST_TAKE = 6'b000010;
	localparam ST_CLEAR = 6'b000100;
	localparam ST_WAIT = 6'b001000;
	localparam ST_CHECK = 6'b010000;
	localparam ST_RECHECK = 6'b100000;

	reg rst_s1_ff;
	reg rst_sync_ff;
	wire rst_n;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_sync_ff <= rst_s1_ff;
		end
	end
	assign rst_n = rst_sync_ff;

	wire [ADDR_W-1:0] out_q_data;
	wire out_q_valid;
	wire out_q_full;
	wire out_q_empty;
	ipsb_fifo #(.WIDTH(ADDR_W), .DEPTH_LOG2(FIFO_LOG2)) u_out_q (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.push_in(out_push_in),
		.push_data_in(out_push_addr_in),
		.pop_in(out_pop_in),
		.pop_data_out(out_q_data),
		.pop_valid_out(out_q_valid),
		.full_out(out_q_full),
		.empty_out(out_q_empty)
	); // RL1

	reg in_pop_ff;
	wire [ADDR_W-1:0] in_q_data;
	wire in_q_valid;
	wire in_q_full;
	wire in_q_empty;
	ipsb_fifo #(.WIDTH(ADDR_W), .DEPTH_LOG2(FIFO_LOG2)) u_in_q (
		.clk_in(clk_in),
		.rst_n_in(rst_n),
		.push_in(in_push_in),
		.push_data_in(in_push_addr_in),
		.pop_in(in_pop_ff),
		.pop_data_out(in_q_data),
		.pop_valid_out(in_q_valid),
		.full_out(in_q_full),
		.empty_out(in_q_empty)
	); // RL2

	// Outbound flags: mbox attn, term attn, term confirm, calendar attn
	reg [3:0] out_flags_ff;
	reg [3:0] req_cnt_ff;
	wire [3:0] raise_mask;
	wire raise_ok;
	wire do_raise;
	assign raise_mask = 4'h1 << raise_index_in; // RL13
	assign raise_ok = !(|(out_flags_ff & raise_mask)) ||
		(operator_comm_active_in && peer_is_console_in); // RL12 RL14
	assign do_raise = raise_peer_signal_in && raise_ok;

	// Watchdog counts after second request while flags stay up
	reg [31:0] wdog_ff;
	reg wdog_run_ff;
	reg [1:0] pend_req_ff;
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			out_flags_ff <= `IPSB_ZERO4;
			out_flags_out <= `IPSB_ZERO4;
			peer_irq_out <= 1'b0;
			raise_busy_out <= 1'b0;
			pend_req_ff <= 2'b00;
			wdog_run_ff <= 1'b0;
			wdog_ff <= `IPSB_ZERO32;
			power_fail_out <= 1'b0;
			req_cnt_ff <= `IPSB_ZERO4;
		end else begin
			out_flags_ff <= (out_flags_ff & ~peer_clear_in) |
				(do_raise ? raise_mask : `IPSB_ZERO4); // RL23 RL8 RL4
			out_flags_out <= (out_flags_ff & ~peer_clear_in) |
				(do_raise ? raise_mask : `IPSB_ZERO4);
			if (do_raise) begin
				peer_irq_out <= 1'b1; // RL3 RL12
			end else if (((out_flags_ff & ~peer_clear_in) == `IPSB_ZERO4)) begin
				peer_irq_out <= 1'b0;
			end
			raise_busy_out <= raise_peer_signal_in && !raise_ok;
			req_cnt_ff <= `IPSB_ZERO4;
			if ((out_flags_ff & ~peer_clear_in) == `IPSB_ZERO4 && !do_raise) begin
				pend_req_ff <= 2'b00;
				wdog_run_ff <= 1'b0;
				wdog_ff <= `IPSB_ZERO32;
			end else begin
				// Refused requests count too: a waiting sender is a second request
				if (raise_peer_signal_in && pend_req_ff != 2'b10) begin
					pend_req_ff <= pend_req_ff + 2'b01;
				end
				if (raise_peer_signal_in && pend_req_ff == 2'b01) begin
					wdog_run_ff <= 1'b1; // RL18
					wdog_ff <= `IPSB_ZERO32;
				end else if (wdog_run_ff) begin
					wdog_ff <= wdog_ff + `IPSB_ONE32;
					if (wdog_ff == WDOG_CYCLES - 1) begin
						power_fail_out <= 1'b1; // RL18
					end
				end
			end
		end
	end

	// Inbound flags: mbox attn, term attn, term confirm, calendar confirm
	reg [3:0] in_flags_ff;
	reg [3:0] local_clr_ff;
	reg [5:0] state_ff;
	reg [5:0] nxt_state;
	reg [3:0] nxt_clr;
	reg [3:0] nxt_dispatch;
	reg nxt_enable;
	reg nxt_periodic;
	wire [3:0] pend;
	assign pend = in_flags_ff;
	always @* begin
		nxt_state = state_ff;
		nxt_clr = `IPSB_ZERO4;
		nxt_dispatch = `IPSB_ZERO4;
		nxt_enable = local_irq_enable_out;
		nxt_periodic = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if ((|pend) && local_irq_enable_out) begin
					nxt_state = ST_TAKE;
				end
			end
			ST_TAKE: begin
				nxt_enable = 1'b0; // RL10
				nxt_state = ST_CLEAR;
			end
			ST_CLEAR: begin
				if (|pend) begin
					nxt_clr = pend & (~pend + 4'h1); // RL11
					nxt_dispatch = pend & (~pend + 4'h1); // RL7
					nxt_state = ST_WAIT;
				end else begin
					nxt_state = ST_CHECK;
				end
			end
			ST_WAIT: begin
				if (handler_done_in) begin
					nxt_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (|pend) begin
					nxt_state = ST_CLEAR; // RL15
				end else begin
					nxt_enable = 1'b1; // RL15
					nxt_state = ST_RECHECK;
				end
			end
			ST_RECHECK: begin
				if (|pend) begin
					nxt_state = ST_TAKE; // RL16
				end else begin
					nxt_periodic = periodic_call_request_in; // RL17
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			in_flags_ff <= `IPSB_ZERO4;
			in_flags_out <= `IPSB_ZERO4;
			local_clr_ff <= `IPSB_ZERO4;
			state_ff <= ST_IDLE;
			dispatch_out <= `IPSB_ZERO4;
			local_irq_enable_out <= 1'b1;
			periodic_service_entry_out <= 1'b0;
		end else begin
			in_flags_ff <= (in_flags_ff & ~nxt_clr) | peer_set_in; // RL23 RL6
			in_flags_out <= (in_flags_ff & ~nxt_clr) | peer_set_in;
			local_clr_ff <= nxt_clr;
			state_ff <= nxt_state;
			dispatch_out <= nxt_dispatch; // RL5
			local_irq_enable_out <= nxt_enable;
			periodic_service_entry_out <= nxt_periodic;
		end
	end

	// Mailbox dispatch from inbound queue, with coalescing timer
	reg [TIMER_W-1:0] timer_ff;
	reg timer_run_ff;
	reg [ADDR_W-1:0] held_addr_ff;
	wire mbox_go;
	assign mbox_go = nxt_dispatch[`IPSB_FLAG_MBOX];
	always @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			in_pop_ff <= 1'b0;
			timer_ff <= {TIMER_W{1'b0}};
			timer_run_ff <= 1'b0;
			held_addr_ff <= {ADDR_W{1'b0}};
			level_queue_addr_out <= {ADDR_W{1'b0}};
			level_queue_valid_out <= 1'b0;
			coalesce_timer_entry_out <= 1'b0;
			instruction_dispatch_out <= 1'b0;
			illegal_instr_out <= 1'b0;
			out_pop_addr_out <= {ADDR_W{1'b0}};
			out_pop_valid_out <= 1'b0;
			out_empty_out <= 1'b1;
			out_full_out <= 1'b0;
			in_full_out <= 1'b0;
		end else begin
			in_pop_ff <= mbox_go && !in_q_empty; // RL20
			level_queue_valid_out <= 1'b0;
			coalesce_timer_entry_out <= 1'b0;
			if (in_q_valid) begin
				if (ASYNC_MAP[mbox_slot_in]) begin
					held_addr_ff <= in_q_data; // RL21
					timer_ff <= timer_initial_value_in;
					timer_run_ff <= 1'b1;
				end else begin
					level_queue_addr_out <= in_q_data; // RL20
					level_queue_valid_out <= 1'b1;
				end
			end else if (timer_run_ff) begin
				if (timer_ff == {TIMER_W{1'b0}} ||
						byte_count_in >= min_bytes_threshold_in) begin
					timer_run_ff <= 1'b0; // RL22
					coalesce_timer_entry_out <= 1'b1;
					level_queue_addr_out <= held_addr_ff;
					level_queue_valid_out <= 1'b1;
				end else begin
					timer_ff <= timer_ff - `IPSB_ONE16; // RL22
				end
			end
			instruction_dispatch_out <= instr_valid_in && IOX_VALID_MAP[instr_num_in]; // RL19
			illegal_instr_out <= instr_valid_in && !IOX_VALID_MAP[instr_num_in]; // RL19
			out_pop_addr_out <= out_q_data;
			out_pop_valid_out <= out_q_valid; // RL1
			out_empty_out <= out_q_empty;
			out_full_out <= out_q_full;
			in_full_out <= in_q_full && !in_full_ack_in;
		end
	end
endmodule
`default_nettype wire

// ---- verif/interprocessor_signal_box_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module interprocessor_signal_box_tb;
	localparam logic [127:0] IMAP = {64{2'b01}};
	logic clk_in = 0, rst_n_in = 0, stall = 1, cal, out_pop_in, in_full_ack_in = 0;
	logic out_push_in = 0, in_push_in = 0, raise_peer_signal_in = 0, instr_valid_in = 0;
	logic operator_comm_active_in = 0, peer_is_console_in = 0;
	logic handler_done_in = 0, periodic_call_request_in = 0;
	logic [15:0] out_push_addr_in = 0, in_push_addr_in = 0, byte_count_in = 0, a;
	logic [15:0] timer_initial_value_in = 0, min_bytes_threshold_in = 16'h0003;
	logic [1:0] raise_index_in = 0;
	logic [6:0] instr_num_in = 0, v;
	logic [3:0] mbox_slot_in = 0, set_ff = 0, seen = 0, m, peer_clear_in;
	wire logic [3:0] peer_set_in = set_ff | {cal, 3'h0};
	logic [15:0] out_pop_addr_out, level_queue_addr_out;
	logic [3:0] out_flags_out, in_flags_out, dispatch_out;
	logic out_pop_valid_out, out_empty_out, out_full_out, in_full_out, raise_busy_out;
	logic peer_irq_out, periodic_service_entry_out, local_irq_enable_out, power_fail_out;
	logic instruction_dispatch_out, illegal_instr_out, level_queue_valid_out;
	logic coalesce_timer_entry_out;
	logic [15:0] eq[$], rq[$];
	int miscompares = 0, num_checks = 0, n;
	ipsb_top #(.WDOG_CYCLES(50), .IOX_VALID_MAP(IMAP), .ASYNC_MAP(16'h0002)) u_dut (.*);
	ipsb_peer u_peer (.clk_in(clk_in), .rst_n_in(rst_n_in), .stall_in(stall),
		.peer_irq_in(peer_irq_out), .flags_in(out_flags_out), .empty_in(out_empty_out),
		.pop_out(out_pop_in), .clear_out(peer_clear_in), .cal_conf_out(cal));
	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		handler_done_in <= rst_n_in && 1'($urandom);
		periodic_call_request_in <= 1'($urandom);
		seen <= set_ff != 4'h0 ? 4'h0 : seen | dispatch_out;
		if (out_pop_valid_out === 1'b1)
			rq.push_back(out_pop_addr_out);
	end
	task automatic chk(input logic [31:0] e, input logic [31:0] g, input string nm);
		num_checks++;
		if (e !== g) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bound(input string nm);
		if (n >= 300) begin
			chk(1, 0, nm);
			conclude();
		end
	endtask
	task automatic idle;
		for (n = 0; n < 300; n++) begin
			@(posedge clk_in);
			#1;
			if (n > 5 && (in_flags_out | out_flags_out) === 4'h0 && local_irq_enable_out === 1'b1)
				break;
		end
		bound("idle");
	endtask
	task automatic raise(input logic [1:0] i, input logic c);
		@(posedge clk_in);
		{raise_peer_signal_in, operator_comm_active_in, peer_is_console_in} <= {1'b1, c, c};
		raise_index_in <= i;
		@(posedge clk_in);
		{raise_peer_signal_in, operator_comm_active_in, peer_is_console_in} <= 3'h0;
		#1;
	endtask
	task automatic mbox(input logic [3:0] s, input logic [15:0] t, input logic [15:0] b,
		input logic c, input int lo, input int hi);
		a = 16'($urandom);
		@(posedge clk_in);
		{in_push_in, in_push_addr_in, mbox_slot_in} <= {1'b1, a, s};
		{timer_initial_value_in, byte_count_in} <= {t, b};
		@(posedge clk_in);
		in_push_in <= 0;
		set_ff <= 4'h1;
		@(posedge clk_in);
		set_ff <= 0;
		for (n = 0; n < 300; n++) begin
			@(posedge clk_in);
			#1;
			if (level_queue_valid_out === 1'b1)
				break;
		end
		bound("level");
		chk(a, level_queue_addr_out, "addr");
		chk(c, coalesce_timer_entry_out, "coal");
		chk(1, n >= lo && n <= hi, "delay");
		idle();
	endtask
	initial begin
		void'($urandom(32'hc26e_db13));
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1;
		repeat (3) @(posedge clk_in);
		for (int i = 0; i < 4; i++) begin
			raise(2'(i), 0);
			chk(1, out_flags_out[i] & peer_irq_out, "flag");
			raise(2'(i), 0);
			chk(1, raise_busy_out, "busy");
			raise(2'(i), 1);
			chk(0, raise_busy_out, "cons");
		end
		@(posedge clk_in);
		stall <= 0;
		idle();
		chk(0, peer_irq_out, "irq");
		chk(0, power_fail_out, "pf0");
		for (int k = 0; k < 6; k++) begin
			m = k == 0 ? 4'hf : 4'($urandom % 15 + 1);
			@(posedge clk_in);
			set_ff <= m;
			@(posedge clk_in);
			set_ff <= 0;
			idle();
			chk(m, seen, "disp");
		end
		mbox(4'h0, 16'h0064, 16'h0000, 0, 0, 30);
		mbox(4'h1, 16'h0028, 16'h0000, 1, 40, 80);
		mbox(4'h1, 16'h0384, 16'h0005, 1, 0, 30);
		for (int k = 0; k < 10; k++) begin
			v = k < 2 ? 7'(k * 127) : 7'($urandom);
			@(posedge clk_in);
			{instr_valid_in, instr_num_in} <= {1'b1, v};
			@(posedge clk_in);
			instr_valid_in <= 0;
			#1;
			chk(!IMAP[v], illegal_instr_out, "ill");
			chk(IMAP[v], instruction_dispatch_out, "iox");
		end
		rq.delete();
		for (int k = 0; k < 9; k++) begin
			a = 16'($urandom);
			eq.push_back(a);
			@(posedge clk_in);
			{stall, out_push_in, out_push_addr_in} <= {2'h3, a};
		end
		@(posedge clk_in);
		out_push_in <= 0;
		repeat (2) @(posedge clk_in);
		#1;
		chk(1, out_full_out, "full");
		@(posedge clk_in);
		stall <= 0;
		for (n = 0; n < 300 && rq.size() < 8; n++)
			@(posedge clk_in);
		bound("pop");
		repeat (6) @(posedge clk_in);
		#1;
		chk(8, rq.size(), "count");
		for (int k = 0; k < 8; k++)
			chk(eq[k], rq[k], "pop");
		chk(1, out_empty_out, "empty");
		@(posedge clk_in);
		stall <= 1;
		raise(2'h0, 0);
		raise(2'h0, 0);
		repeat (60) @(posedge clk_in);
		#1;
		chk(1, power_fail_out, "pf");
		conclude();
	end
endmodule
`default_nettype wire

// ---- verif/ipsb_peer.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipsb_peer (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic stall_in,
	input wire logic peer_irq_in,
	input wire logic [3:0] flags_in,
	input wire logic empty_in,
	output logic pop_out,
	output logic [3:0] clear_out,
	output logic cal_conf_out
);
	logic [3:0] wait_ff;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_ff <= 4'h0;
			pop_out <= 1'b0;
			clear_out <= 4'h0;
			cal_conf_out <= 1'b0;
		end else begin
			pop_out <= !stall_in && !empty_in && !pop_out;
			clear_out <= 4'h0;
			cal_conf_out <= 1'b0;
			if (!peer_irq_in || stall_in) begin
				wait_ff <= 4'($urandom % 8);
			end else if (wait_ff != 4'h0) begin
				wait_ff <= wait_ff - 4'h1;
			end else begin
				clear_out <= flags_in;
				cal_conf_out <= flags_in[3];
				wait_ff <= 4'hf;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/ipsb_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module ipsb_props #(
	parameter logic [127:0] IOX_VALID_MAP = {128{1'b1}}
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic raise_peer_signal_in,
	input wire logic [1:0] raise_index_in,
	input wire logic operator_comm_active_in,
	input wire logic peer_is_console_in,
	input wire logic raise_busy_out,
	input wire logic [3:0] peer_clear_in,
	input wire logic [3:0] out_flags_out,
	input wire logic peer_irq_out,
	input wire logic [3:0] peer_set_in,
	input wire logic [3:0] in_flags_out,
	input wire logic [3:0] dispatch_out,
	input wire logic local_irq_enable_out,
	input wire logic periodic_call_request_in,
	input wire logic periodic_service_entry_out,
	input wire logic instr_valid_in,
	input wire logic [6:0] instr_num_in,
	input wire logic instruction_dispatch_out,
	input wire logic illegal_instr_out,
	input wire logic power_fail_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic cons = operator_comm_active_in && peer_is_console_in;
	wire logic rq = raise_peer_signal_in;
	AST_RAISE_SETS:
	assert property (rq && (!out_flags_out[raise_index_in] || cons)
		|=> out_flags_out[$past(raise_index_in)] && peer_irq_out) else $error("raise lost");
	AST_RAISE_BUSY:
	assert property (rq && out_flags_out[raise_index_in] && !cons |=> raise_busy_out)
		else $error("busy missing");
	AST_CONSOLE:
	assert property (rq && cons |=> !raise_busy_out) else $error("console waited");
	AST_IRQ_LINE:
	assert property (peer_irq_out == (|out_flags_out)) else $error("line mismatch");
	AST_OUT_HOLD:
	assert property (out_flags_out != 4'h0
		|=> ($past(out_flags_out & ~peer_clear_in) & ~out_flags_out) == 4'h0)
		else $error("flag dropped");
	AST_SET_WINS:
	assert property (peer_set_in != 4'h0
		|=> (in_flags_out & $past(peer_set_in)) == $past(peer_set_in)) else $error("set lost");
	AST_DISP_PULSE:
	assert property (dispatch_out != 4'h0 |-> $onehot(dispatch_out) && !local_irq_enable_out
		##1 dispatch_out == 4'h0) else $error("dispatch shape");
	AST_DISP_CAUSE:
	assert property (dispatch_out != 4'h0 |-> ($past(in_flags_out) & dispatch_out) != 4'h0)
		else $error("dispatch without flag");
	AST_ILLEGAL:
	assert property (instr_valid_in |=> illegal_instr_out == !IOX_VALID_MAP[$past(instr_num_in)]
		&& instruction_dispatch_out == IOX_VALID_MAP[$past(instr_num_in)])
		else $error("lookup wrong");
	AST_PERIODIC:
	assert property (periodic_service_entry_out |-> $past(periodic_call_request_in)
		&& local_irq_enable_out) else $error("periodic entry without request");
	AST_PFAIL_STICKY:
	assert property (power_fail_out |=> power_fail_out) else $error("power fail dropped");
	cover property (rq && out_flags_out[raise_index_in] && !cons);
	cover property (dispatch_out != 4'h0);
	cover property (illegal_instr_out);
	cover property ($rose(power_fail_out));
endmodule
bind ipsb_top ipsb_props #(.IOX_VALID_MAP(IOX_VALID_MAP)) u_props (.*);
`default_nettype wire
